// file: pkg/rmii_cfg_pkg.sv
package rmii_cfg_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int REG_W = 16;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_BASIC_CTRL = 10'h000;
    localparam logic [9:0] IDX_REDUCED_MODE = 10'h017;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h018;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h019;
    // field positions
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_REDUCED = 5;
    localparam int BIT_LEGACY = 4;
    localparam int BIT_OVF = 3;
    localparam int BIT_UNF = 2;
    localparam int ELAST_LSB = 0;
    localparam int ELAST_W = 2;
    localparam int RESERVED_LSB = 6;
    // reset values
    localparam logic [REG_W-1:0] RST_BASIC_CTRL = 16'h0000;
    localparam logic [ELAST_W-1:0] RST_ELAST = 2'h1;
    localparam logic RST_LEGACY = 1'b0;
    // interrupt status layout
    localparam int IRQ_W = 3;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_UNF = 1;
    localparam int IRQ_END = 2;
    // elasticity buffer, counted in nibbles of 4 bits
    localparam int NIB_W = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam int LVL_W = 4;
    localparam logic [ELAST_W-1:0] ELAST_CODE_16 = 2'h0;
    localparam logic [LVL_W-1:0] THRESH_NIB_16 = 4'h4;
    // receive di-bit patterns
    localparam logic [1:0] IDLE_DIBIT = 2'h0;
    localparam logic [1:0] CORRUPT_DIBIT = 2'h1;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_FILL = 2'b01,
        RX_STREAM = 2'b10
    } rx_state_t;
endpackage

// file: rtl/rx_elastic_fifo.sv
`timescale 1ns/1ps
module rx_elastic_fifo
    import rmii_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush,
    input wire logic wr_valid,
    input wire logic [NIB_W-1:0] wr_data,
    output logic wr_ready,
    input wire logic rd_pop,
    output logic [NIB_W-1:0] rd_data,
    output logic empty,
    output logic [LVL_W-1:0] level,
    output logic overflow
);
    logic [NIB_W-1:0] mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr;
    logic [FIFO_AW-1:0] rd_ptr;
    logic do_wr;
    logic do_rd;

    assign wr_ready = (level != LVL_W'(FIFO_DEPTH));
    assign empty = (level == '0);
    assign do_wr = wr_valid && wr_ready && !flush;
    assign do_rd = rd_pop && !empty && !flush;
    assign rd_data = mem[rd_ptr];
    // a nibble offered while full is lost and reported
    assign overflow = wr_valid && !wr_ready && !flush;

    always_ff @(posedge pclk) begin
        if (do_wr) begin
            mem[wr_ptr] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                level <= level + 1'b1;
            end else if (do_rd && !do_wr) begin
                level <= level - 1'b1;
            end
        end
    end
endmodule // rx_elastic_fifo

// file: rtl/carrier_valid_gen.sv
`timescale 1ns/1ps
module carrier_valid_gen (
    input wire logic carrier,
    input wire logic busy,
    input wire logic first_dibit,
    input wire logic legacy_carrier_valid_select,
    output logic crs_dv
);
    // legacy: held until the last data; otherwise low on first di-bits once carrier is gone
    always_comb begin
        if (legacy_carrier_valid_select) begin
            crs_dv = carrier || busy;
        end else begin
            crs_dv = carrier || (busy && !first_dibit);
        end
    end
endmodule // carrier_valid_gen

// file: rtl/rmii_mode_config.sv
// Design decision made here: the APB register port.
`timescale 1ns/1ps
// Function
// RULE_01: strap low gives four-bit, high two-bit mode
// RULE_02: strap caught only at reset release
// RULE_03: mode bit 5 from strap, read-write
// RULE_04: bits 15:6 ignore writes, read zero
// RULE_05: bit 4 selects toggling or held carrier-valid
// RULE_06: bit 3 read-only overflow flag
// RULE_07: bit 2 read-only underflow flag
// RULE_08: bits 1:0 tolerance field, resets to 01
// RULE_09: field sets start threshold in nibbles
// RULE_10: reduced receive passes through elasticity buffer
// RULE_11: overrun or underrun corrupts the frame data
// RULE_12: standard mode bypasses reduced-interface path
// RULE_13: control bit 14 loops MAC transmit back
// RULE_14: MAC disables collision detect in loopback
// RULE_15: software picks threshold from size, accuracy
// RULE_16: carrier-valid falls only on first di-bits
// RULE_17: default threshold sets receive latency
// RULE_18: status flags stay set until reset
// RULE_19: buffer flushed per event, refilled to threshold
module rmii_mode_config
    import rmii_cfg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mode_strap,
    input wire logic rx_carrier,
    input wire logic rx_nibble_valid,
    input wire logic [NIB_W-1:0] rx_nibble,
    output logic rx_nibble_ready,
    input wire logic tx_en,
    input wire logic [NIB_W-1:0] txd,
    output logic line_tx_en,
    output logic [NIB_W-1:0] line_txd,
    output logic mii_rx_dv,
    output logic mii_crs,
    output logic [NIB_W-1:0] mii_rxd,
    output logic rmii_crs_dv,
    output logic [1:0] rmii_rxd,
    output logic rmii_rx_er,
    output logic reduced_mode,
    output logic irq
);
    logic [REG_W-1:0] basic_mode_control_reg;
    logic strap_done;
    logic legacy_carrier_valid_select;
    logic rx_overflow_flag;
    logic rx_underflow_flag;
    logic [ELAST_W-1:0] elasticity_threshold;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_events;
    logic [9:0] word_idx;
    logic hit_basic;
    logic hit_reduced;
    logic hit_status;
    logic hit_mask;
    logic mapped;
    logic wr_access;
    logic loopback;
    logic [REG_W-1:0] reduced_mode_bypass_reg;
    logic [DATA_W-1:0] next_rdata;
    rx_state_t state;
    rx_state_t next_state;
    logic pop;
    logic underflow_evt;
    logic end_evt;
    logic fifo_flush;
    logic fifo_wr;
    logic fifo_empty;
    logic fifo_overflow;
    logic [NIB_W-1:0] fifo_rd_data;
    logic [LVL_W-1:0] fifo_level;
    logic [LVL_W-1:0] thresh_nib;
    logic dibit_sel;
    logic [1:0] hi_dibit;
    logic corrupt;
    logic corrupt_now;
    logic presenting_first;
    logic next_crs_dv;
    logic [1:0] next_rxd;
    logic rmii_first_out;

    // ---------------- APB slave ----------------
    assign word_idx = paddr[ADDR_W-1:2];
    assign hit_basic = (word_idx == IDX_BASIC_CTRL);
    assign hit_reduced = (word_idx == IDX_REDUCED_MODE);
    assign hit_status = (word_idx == IDX_IRQ_STATUS);
    assign hit_mask = (word_idx == IDX_IRQ_MASK);
    assign mapped = hit_basic || hit_reduced || hit_status || hit_mask;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_access = psel && penable && pwrite && mapped;
    assign loopback = basic_mode_control_reg[BIT_LOOPBACK];

    // reserved bits 15:6 are constant zero
    always_comb begin
        reduced_mode_bypass_reg = '0; // [RULE_04]
        reduced_mode_bypass_reg[BIT_REDUCED] = reduced_mode;
        reduced_mode_bypass_reg[BIT_LEGACY] = legacy_carrier_valid_select;
        reduced_mode_bypass_reg[BIT_OVF] = rx_overflow_flag; // [RULE_06]
        reduced_mode_bypass_reg[BIT_UNF] = rx_underflow_flag; // [RULE_07]
        reduced_mode_bypass_reg[ELAST_LSB +: ELAST_W] = elasticity_threshold;
    end

    always_comb begin
        next_rdata = '0;
        if (hit_basic) begin
            next_rdata[REG_W-1:0] = basic_mode_control_reg;
        end else if (hit_reduced) begin
            next_rdata[REG_W-1:0] = reduced_mode_bypass_reg;
        end else if (hit_status) begin
            next_rdata[IRQ_W-1:0] = irq_status;
        end else if (hit_mask) begin
            next_rdata[IRQ_W-1:0] = irq_mask;
        end
    end

    // read data captured in the setup phase so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable) begin
            prdata <= next_rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            basic_mode_control_reg <= RST_BASIC_CTRL;
        end else if (wr_access && hit_basic) begin
            basic_mode_control_reg <= pwdata[REG_W-1:0]; // [RULE_13]
        end
    end

    // strap caught once on the first edge after release, then software owns the bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done <= 1'b0;
            reduced_mode <= 1'b0;
        end else if (!strap_done) begin
            strap_done <= 1'b1; // [RULE_02]
            reduced_mode <= mode_strap; // [RULE_01] [RULE_03]
        end else if (wr_access && hit_reduced) begin
            reduced_mode <= pwdata[BIT_REDUCED]; // [RULE_03]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            legacy_carrier_valid_select <= RST_LEGACY; // [RULE_05]
            elasticity_threshold <= RST_ELAST; // [RULE_08] [RULE_17]
        end else if (wr_access && hit_reduced) begin
            legacy_carrier_valid_select <= pwdata[BIT_LEGACY];
            elasticity_threshold <= pwdata[ELAST_LSB +: ELAST_W]; // [RULE_08]
        end
    end

    // sticky until reset; software cannot clear them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_overflow_flag <= 1'b0;
            rx_underflow_flag <= 1'b0;
        end else begin
            if (fifo_overflow) begin
                rx_overflow_flag <= 1'b1; // [RULE_06] [RULE_18]
            end
            if (underflow_evt) begin
                rx_underflow_flag <= 1'b1; // [RULE_07] [RULE_18]
            end
        end
    end

    // ---------------- interrupts ----------------
    always_comb begin
        irq_events = '0;
        irq_events[IRQ_OVF] = fifo_overflow;
        irq_events[IRQ_UNF] = underflow_evt;
        irq_events[IRQ_END] = end_evt;
    end

    // write-one-to-clear; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (wr_access && hit_status) begin
            irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= '0;
        end else if (wr_access && hit_mask) begin
            irq_mask <= pwdata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ---------------- reduced receive path ----------------
    // code 0 means four nibbles, other codes that many nibbles
    assign thresh_nib = (elasticity_threshold == ELAST_CODE_16) ? THRESH_NIB_16 :
        LVL_W'(elasticity_threshold); // [RULE_09]

    always_comb begin
        next_state = state;
        pop = 1'b0;
        underflow_evt = 1'b0;
        end_evt = 1'b0;
        case (state)
            RX_IDLE: begin
                if (reduced_mode && !loopback && rx_carrier) begin
                    next_state = RX_FILL; // [RULE_10]
                end
            end
            RX_FILL: begin
                if (fifo_level >= thresh_nib || (!rx_carrier && !fifo_empty)) begin
                    next_state = RX_STREAM; // [RULE_09] [RULE_19]
                end else if (!rx_carrier) begin
                    next_state = RX_IDLE;
                    end_evt = 1'b1;
                end
            end
            RX_STREAM: begin
                if (!dibit_sel) begin
                    if (!fifo_empty) begin
                        pop = 1'b1;
                    end else if (rx_carrier) begin
                        underflow_evt = 1'b1; // [RULE_11]
                    end else begin
                        next_state = RX_IDLE;
                        end_evt = 1'b1;
                    end
                end
            end
            default: begin
                next_state = RX_IDLE;
            end
        endcase
        if (!reduced_mode || loopback) begin
            next_state = RX_IDLE; // [RULE_12]
            pop = 1'b0;
            underflow_evt = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RX_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // idle keeps the buffer empty so each event refills from zero
    assign fifo_flush = (next_state == RX_IDLE); // [RULE_19]
    assign fifo_wr = rx_nibble_valid && reduced_mode && !loopback;

    rx_elastic_fifo u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(fifo_flush),
        .wr_valid(fifo_wr),
        .wr_data(rx_nibble),
        .wr_ready(),
        .rd_pop(pop),
        .rd_data(fifo_rd_data),
        .empty(fifo_empty),
        .level(fifo_level),
        .overflow(fifo_overflow)
    );

    assign rx_nibble_ready = 1'b1;

    // frame spoiled from the first overrun or underrun until the event ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            corrupt <= 1'b0;
        end else if (fifo_overflow || underflow_evt) begin
            corrupt <= 1'b1; // [RULE_11]
        end else if (state == RX_IDLE) begin
            corrupt <= 1'b0;
        end
    end

    assign corrupt_now = corrupt || fifo_overflow || underflow_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dibit_sel <= 1'b0;
            hi_dibit <= IDLE_DIBIT;
        end else if (pop) begin
            dibit_sel <= 1'b1;
            hi_dibit <= fifo_rd_data[NIB_W-1:2];
        end else begin
            dibit_sel <= 1'b0;
        end
    end

    assign presenting_first = (state == RX_STREAM) && !dibit_sel;

    always_comb begin
        next_rxd = IDLE_DIBIT;
        if (state == RX_STREAM && next_state != RX_IDLE) begin
            if (corrupt_now) begin
                next_rxd = CORRUPT_DIBIT; // [RULE_11]
            end else if (pop) begin
                next_rxd = fifo_rd_data[1:0];
            end else begin
                next_rxd = hi_dibit;
            end
        end else if (state == RX_STREAM && dibit_sel) begin
            next_rxd = corrupt_now ? CORRUPT_DIBIT : hi_dibit;
        end
    end

    carrier_valid_gen u_crs (
        .carrier(rx_carrier),
        .busy(next_state != RX_IDLE),
        .first_dibit(presenting_first),
        .legacy_carrier_valid_select(legacy_carrier_valid_select),
        .crs_dv(next_crs_dv)
    );

    // reduced interface outputs; loopback returns the MAC's own di-bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rmii_crs_dv <= 1'b0;
            rmii_rxd <= IDLE_DIBIT;
            rmii_rx_er <= 1'b0;
            rmii_first_out <= 1'b0;
        end else if (!reduced_mode) begin
            rmii_crs_dv <= 1'b0; // [RULE_12]
            rmii_rxd <= IDLE_DIBIT;
            rmii_rx_er <= 1'b0;
            rmii_first_out <= 1'b0;
        end else if (loopback) begin
            rmii_crs_dv <= tx_en; // [RULE_13]
            rmii_rxd <= tx_en ? txd[1:0] : IDLE_DIBIT;
            rmii_rx_er <= 1'b0;
            rmii_first_out <= 1'b0;
        end else begin
            rmii_crs_dv <= (state == RX_IDLE) ? rx_carrier : next_crs_dv; // [RULE_05] [RULE_16]
            rmii_rxd <= next_rxd;
            rmii_rx_er <= (state == RX_STREAM) && corrupt_now;
            rmii_first_out <= presenting_first;
        end
    end

    // standard interface path, used when reduced mode is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mii_rx_dv <= 1'b0;
            mii_crs <= 1'b0;
            mii_rxd <= '0;
        end else if (reduced_mode) begin
            mii_rx_dv <= 1'b0;
            mii_crs <= 1'b0;
            mii_rxd <= '0;
        end else if (loopback) begin
            mii_rx_dv <= tx_en; // [RULE_13]
            mii_crs <= tx_en;
            mii_rxd <= tx_en ? txd : '0;
        end else begin
            mii_rx_dv <= rx_nibble_valid; // [RULE_12]
            mii_crs <= rx_carrier;
            mii_rxd <= rx_nibble_valid ? rx_nibble : '0;
        end
    end

    // transmit to the line is held off during loopback
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_tx_en <= 1'b0;
            line_txd <= '0;
        end else if (loopback) begin
            line_tx_en <= 1'b0;
            line_txd <= '0;
        end else begin
            line_tx_en <= tx_en;
            line_txd <= reduced_mode ? {2'b00, txd[1:0]} : txd;
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_fill_done;
        state == RX_FILL && next_state == RX_STREAM;
    endsequence

    property p_reserved_zero;
        psel && !penable && !pwrite && hit_reduced |=> prdata[DATA_W-1:RESERVED_LSB] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero"); // [RULE_04]

    property p_strap_latch;
        $rose(strap_done) |-> reduced_mode == $past(mode_strap);
    endproperty
    a_strap_latch: assert property (p_strap_latch) else $error("strap not latched"); // [RULE_02]

    property p_ovf_sticky;
        fifo_overflow |=> rx_overflow_flag [*4];
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost"); // [RULE_18]

    property p_unf_flag;
        underflow_evt |=> rx_underflow_flag && rmii_rxd == CORRUPT_DIBIT;
    endproperty
    a_unf_flag: assert property (p_unf_flag) else $error("underflow not reported"); // [RULE_07]

    property p_fill_threshold;
        s_fill_done |-> fifo_level >= thresh_nib || !rx_carrier;
    endproperty
    a_fill_threshold: assert property (p_fill_threshold) else $error("stream began early"); // [RULE_09]

    property p_corrupt_out;
        state == RX_STREAM && corrupt && next_state == RX_STREAM |=> rmii_rxd == CORRUPT_DIBIT;
    endproperty
    a_corrupt_out: assert property (p_corrupt_out) else $error("corrupt frame not spoiled"); // [RULE_11]

    property p_bypass;
        !reduced_mode |=> !rmii_crs_dv && rmii_rxd == IDLE_DIBIT && state == RX_IDLE;
    endproperty
    a_bypass: assert property (p_bypass) else $error("reduced path active in standard mode"); // [RULE_12]

    property p_rev12_fall;
        reduced_mode && !loopback && !legacy_carrier_valid_select && $fell(rmii_crs_dv)
            && !$past(rx_carrier) && state != RX_IDLE |-> rmii_first_out;
    endproperty
    a_rev12_fall: assert property (p_rev12_fall) else $error("carrier-valid fell mid nibble"); // [RULE_16]

    property p_legacy_hold;
        legacy_carrier_valid_select && !loopback && reduced_mode && state == RX_STREAM
            && next_state == RX_STREAM |=> rmii_crs_dv;
    endproperty
    a_legacy_hold: assert property (p_legacy_hold) else $error("legacy carrier-valid toggled"); // [RULE_05]

    property p_loopback;
        reduced_mode && loopback ##1 reduced_mode && loopback |-> rmii_crs_dv == $past(tx_en);
    endproperty
    a_loopback: assert property (p_loopback) else $error("loopback not echoed"); // [RULE_13]
endmodule // rmii_mode_config

// file: verif/rmii_mac_model.sv
`timescale 1ns/1ps
module rmii_mac_model (
    input wire logic pclk,
    input wire logic crs_dv,
    input wire logic [1:0] rxd,
    input wire logic rx_er,
    output logic tx_en,
    output logic [3:0] txd
);
    logic [1:0] got[$];
    logic saw_er;
    int n_dv;
    initial begin
        tx_en = 1'b0;
        txd = 4'h0;
        saw_er = 1'b0;
        n_dv = 0;
    end
    // collect from the first non-idle di-bit while carrier-valid stands
    always @(posedge pclk) begin
        if (crs_dv === 1'b1 && (got.size() > 0 || rxd !== 2'h0)) got.push_back(rxd);
        if (crs_dv === 1'b1) n_dv++;
        if (rx_er === 1'b1) saw_er = 1'b1;
    end
    // own collision detection stays off, so looped frames are never flagged
    task tx(input logic en, input logic [3:0] d);
        @(posedge pclk);
        tx_en <= en;
        txd <= en ? d : ~txd;
    endtask
endmodule // rmii_mac_model

// file: verif/rmii_mode_config_elastic_buffer_tb_top.sv
`timescale 1ns/1ps
module rmii_mode_config_elastic_buffer_tb_top;
    import rmii_cfg_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mode_strap = 0;
    logic rx_carrier = 0, rx_nibble_valid = 0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic [NIB_W-1:0] rx_nibble = '0, txd, line_txd, mii_rxd;
    logic pready, pslverr, rx_nibble_ready, tx_en, line_tx_en, mii_rx_dv, mii_crs;
    logic rmii_crs_dv, rmii_rx_er, reduced_mode, irq, err;
    logic [1:0] rmii_rxd;
    logic [1:0] exp_q[$];
    logic [3:0] d;
    int n_mismatch = 0, n_compared = 0, mii_cnt = 0, i, k;
    integer seed = 32'h2ee56db9;
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) if (mii_rx_dv === 1'b1) mii_cnt++;
    rmii_mode_config u_rmii_mode_config (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode_strap(mode_strap), .rx_carrier(rx_carrier),
        .rx_nibble_valid(rx_nibble_valid), .rx_nibble(rx_nibble),
        .rx_nibble_ready(rx_nibble_ready), .tx_en(tx_en), .txd(txd), .line_tx_en(line_tx_en),
        .line_txd(line_txd), .mii_rx_dv(mii_rx_dv), .mii_crs(mii_crs), .mii_rxd(mii_rxd),
        .rmii_crs_dv(rmii_crs_dv), .rmii_rxd(rmii_rxd), .rmii_rx_er(rmii_rx_er),
        .reduced_mode(reduced_mode), .irq(irq));
    rmii_mac_model u_rmii_mac_model (.pclk(pclk), .crs_dv(rmii_crs_dv), .rxd(rmii_rxd),
        .rx_er(rmii_rx_er), .tx_en(tx_en), .txd(txd));
    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask
    task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rdchk(input logic [9:0] idx, input logic [31:0] e);
        apb(0, idx, 0);
        chk("register", e, rd);
    endtask
    task rst(input logic s);
        presetn <= 0;
        mode_strap <= s;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        repeat (2) @(posedge pclk);
        mode_strap <= ~s;
        repeat (2) @(posedge pclk);
        chk("reduced_mode", {31'h0, s}, {31'h0, reduced_mode});
    endtask
    task frame(input int n, input int gap);
        u_rmii_mac_model.got.delete();
        u_rmii_mac_model.saw_er = 0;
        exp_q.delete();
        @(posedge pclk);
        rx_carrier <= 1;
        for (k = 0; k < n; k++) begin
            d = (k == 0) ? 4'h5 : 4'($random(seed));
            exp_q.push_back(d[1:0]);
            exp_q.push_back(d[3:2]);
            @(posedge pclk);
            rx_nibble_valid <= 1;
            rx_nibble <= d;
            if (gap > 1) begin
                @(posedge pclk);
                rx_nibble_valid <= 0;
                rx_nibble <= ~d;
                repeat (gap - 2) @(posedge pclk);
            end
        end
        @(posedge pclk);
        rx_nibble_valid <= 0;
        rx_carrier <= 0;
        repeat (40) @(posedge pclk);
    endtask
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge pclk);
        n_mismatch++;
        stop_test;
    end
    initial begin
        rst(0);
        rst(1);
        rdchk(IDX_REDUCED_MODE, 32'h21);
        rdchk(IDX_BASIC_CTRL, 32'h0);
        apb(1, IDX_REDUCED_MODE, 32'hffff_ffff);
        rdchk(IDX_REDUCED_MODE, 32'h33);
        apb(0, 10'h3ff, 0);
        chk("unmapped_err", 1, {31'h0, err});
        $display("test registers done");
        // software picks each start threshold in turn
        for (i = 0; i < 4; i++) begin
            apb(1, IDX_REDUCED_MODE, 32'h30 | i);
            frame(12, 2);
            chk("rx_len", exp_q.size(), u_rmii_mac_model.got.size());
            if (exp_q.size() == u_rmii_mac_model.got.size())
                for (k = 0; k < exp_q.size(); k++)
                    chk("rx_dibit", exp_q[k], u_rmii_mac_model.got[k]);
            chk("rx_er", 0, u_rmii_mac_model.saw_er);
        end
        $display("test thresholds done");
        apb(1, IDX_REDUCED_MODE, 32'h21);
        frame(6, 4);
        chk("unf_er", 1, u_rmii_mac_model.saw_er);
        rdchk(IDX_REDUCED_MODE, 32'h25);
        chk("irq_masked", 0, irq);
        frame(20, 1);
        chk("ovf_er", 1, u_rmii_mac_model.saw_er);
        rdchk(IDX_REDUCED_MODE, 32'h2d);
        apb(1, IDX_IRQ_MASK, 32'h1);
        @(posedge pclk);
        chk("irq_on", 1, irq);
        apb(1, IDX_IRQ_STATUS, 32'h1);
        @(posedge pclk);
        chk("irq_off", 0, irq);
        rdchk(IDX_IRQ_STATUS, 32'h6);
        $display("test faults done");
        apb(1, IDX_REDUCED_MODE, 32'h1);
        u_rmii_mac_model.n_dv = 0;
        mii_cnt = 0;
        frame(4, 2);
        chk("rmii_quiet", 0, u_rmii_mac_model.n_dv);
        chk("mii_seen", 1, mii_cnt != 0);
        $display("test standard done");
        apb(1, IDX_REDUCED_MODE, 32'h21);
        apb(1, IDX_BASIC_CTRL, 32'h4000);
        rdchk(IDX_BASIC_CTRL, 32'h4000);
        for (i = 0; i < 8; i++) begin
            d = 4'($random(seed));
            u_rmii_mac_model.tx(1, d);
            @(posedge pclk);
            #1;
            chk("loop_rxd", d[1:0], rmii_rxd);
            chk("line_quiet", 0, line_tx_en);
        end
        u_rmii_mac_model.tx(0, 0);
        // standard interface loopback, then the line path once loopback is off
        apb(1, IDX_REDUCED_MODE, 32'h1);
        d = 4'($random(seed));
        u_rmii_mac_model.tx(1, d);
        @(posedge pclk);
        #1;
        chk("mii_loop", {4'h3, d}, {2'b0, mii_crs, mii_rx_dv, mii_rxd});
        apb(1, IDX_BASIC_CTRL, 32'h0);
        @(posedge pclk);
        #1;
        chk("line_txd", {4'h1, d}, {3'b0, line_tx_en, line_txd});
        chk("ready", 3, {pready, rx_nibble_ready});
        u_rmii_mac_model.tx(0, 0);
        $display("test loopback done");
        stop_test;
    end
endmodule // rmii_mode_config_elastic_buffer_tb_top
